// ---- common/dfcs_params.svh ----
// constants for the dual flash command sequencer
`ifndef DFCS_PARAMS_SVH
`define DFCS_PARAMS_SVH
// system clock
`define DFCS_CLK_NS 10
// command addresses, low twelve bits only
`define DFCS_UL1_ADDR 12'hAAA
`define DFCS_UL2_ADDR 12'h554
// command bytes
`define DFCS_B_UL1 8'hAA
`define DFCS_B_UL2 8'h55
`define DFCS_B_AUTO 8'h90
`define DFCS_B_PROG 8'hA0
`define DFCS_B_ERASE 8'h80
`define DFCS_B_SECT 8'h30
`define DFCS_B_BULK 8'h10
`define DFCS_B_SUSP 8'hB0
`define DFCS_B_RESET 8'hF0
`define DFCS_B_BYP 8'h20
`define DFCS_B_BYPX 8'h00
// special read locations and answers
`define DFCS_ID_RD_ADDR 8'h02
`define DFCS_PROT_RD_ADDR 8'h04
`define DFCS_PROT_YES 8'h01
`define DFCS_PROT_NO 8'h00
// times in ns
`define DFCS_GAP_NS 50000
`define DFCS_SECT_WIN_NS 80000
`define DFCS_PROG_NS 10000
`define DFCS_ERASE_NS 1000000
`endif

// ---- common/dfcs_pkg.sv ----
// types shared by the sequencer files
package dfcs_pkg;
  // sequencer states, gray steps along unlock path
  typedef enum logic [3:0] {
    DFCS_READ = 4'h0,
    DFCS_UL1 = 4'h1,
    DFCS_UL2 = 4'h3,
    DFCS_E80 = 4'h2,
    DFCS_E_UL1 = 4'h6,
    DFCS_E_UL2 = 4'h7,
    DFCS_SWIN = 4'h5,
    DFCS_ERASE = 4'h4,
    DFCS_PDATA = 4'hC,
    DFCS_PROG = 4'hD,
    DFCS_AUTO = 4'hF,
    DFCS_BYP90 = 4'hE
  } dfcs_state_t;
  typedef logic [23:0] dfcs_cnt_t;
endpackage

// ---- common/dfcs_tmr_if.sv ----
// load and expiry signals between sequencer and a countdown timer
`timescale 1ns/10ps
`default_nettype none
interface dfcs_tmr_if;
  logic load;
  logic hold;
  logic done;
  dfcs_pkg::dfcs_cnt_t value;
  modport ctl(output load, output hold, output value, input done);
  modport tmr(input load, input hold, input value, output done);
endinterface
`default_nettype wire

// ---- design/dfcs_timer.sv ----
// countdown timer that can be paused and reloaded
`timescale 1ns/10ps
`default_nettype none
module dfcs_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // control from the sequencer
  dfcs_tmr_if.tmr t
);
  import dfcs_pkg::*;
  dfcs_cnt_t cnt;
  dfcs_cnt_t next_cnt;

  // reload wins over counting so a late byte restarts the gap cleanly
  always_comb begin
    next_cnt = cnt;
    if (t.load) begin
      next_cnt = t.value;
    end else if (cnt != '0 && !t.hold) begin
      next_cnt = cnt - 24'h000001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // one-cycle pulse on the last count
  assign t.done = (cnt == 24'h000001) && !t.hold && !t.load;
endmodule
`default_nettype wire

// ---- design/dfcs_top.sv ----
// command decoder and program/erase sequencer for two flash arrays
`timescale 1ns/10ps
`default_nettype none
`include "dfcs_params.svh"
// Notes on behaviour
// R1: eight and four sectors, each protectable
// R2: sector erase, word program, erase suspend
// R3: ready low while programming or erasing
// R4: sector select is OR of three terms
// R5: selects route instruction to its array
// R6: plain writes never store array data
// R7: every command opens with two unlocks, except B0h, 30h, F0h and the bypass A0h, 90h, 00h
// R8: only low twelve address bits compared
// R9: address at strobe fall, data at rise
// R10: identifier read only on primary array
// R11: protection read returns 01h or 00h
// R12: sector erase with queued sectors window
// R13: bulk erase clears unprotected sectors
// R14: B0h pauses sector erase only
// R15: 30h resumes a paused erase
// R16: F0h returns to read, clears error
// R17: 20h enters bypass, short program
// R18: 90h then 00h leaves bypass mode
// R19: execute only complete timely sequences
// R20: bad byte or timeout returns read
// R21: host writes bytes to even addresses
// R22: don't care addresses are even
// R23: reset puts both arrays in read
// R24: timeout and durations are parameters
// R25: protected targets abort without change
module dfcs_top #(
  parameter int AW = 16,
  parameter int GAP_CYC = `DFCS_GAP_NS / `DFCS_CLK_NS,
  parameter int SWIN_CYC = `DFCS_SECT_WIN_NS / `DFCS_CLK_NS,
  parameter int PROG_CYC = (`DFCS_PROG_NS + `DFCS_CLK_NS - 1) / `DFCS_CLK_NS,
  parameter int ERASE_CYC = (`DFCS_ERASE_NS + `DFCS_CLK_NS - 1) / `DFCS_CLK_NS,
  parameter logic [15:0] ID_CODE = 16'h005A // arbitrary value
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // host bus pins
  input wire logic i_write_strobe_pin_n,
  input wire logic [AW-1:0] i_addr,
  input wire logic [15:0] i_data,
  // product terms from the decode_logic_array
  input wire logic [7:0][2:0] i_primary_terms,
  input wire logic [3:0][2:0] i_secondary_terms,
  // protection bits and array macro
  input wire logic [7:0] i_primary_protect,
  input wire logic [3:0] i_secondary_protect,
  input wire logic [15:0] i_array_rdata,
  input wire logic i_array_fail,
  // status
  output logic o_ready_busy_pin,
  output logic o_error_flag_bit,
  output logic o_bypass_mode,
  output logic o_erase_paused,
  // read data to host
  output logic [15:0] o_read_data,
  // array macro control
  output logic o_array_prog,
  output logic o_array_erase,
  output logic o_array_sel,
  output logic [AW-1:0] o_array_addr,
  output logic [15:0] o_array_wdata,
  output logic [7:0] o_erase_mask
);
  import dfcs_pkg::*;
  localparam int BW = 1 + AW + 16 + 24 + 12;

  // three-flop synchroniser for the whole pin bundle
  logic [BW-1:0] s1, s2, s3;
  logic wr_lvl, next_wr_lvl;
  logic wr_b;
  logic [AW-1:0] bus_addr;
  logic [15:0] bus_data;
  logic [7:0][2:0] pt;
  logic [3:0][2:0] st;
  logic [7:0] psel;
  logic [3:0] ssel;
  logic [AW-1:0] cap_addr, next_cap_addr;
  logic wr_fall, wr_rise;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1 <= {1'b1, {(BW-1){1'b0}}};
      s2 <= {1'b1, {(BW-1){1'b0}}};
      s3 <= {1'b1, {(BW-1){1'b0}}};
    end else begin
      s1 <= {i_write_strobe_pin_n, i_addr, i_data, i_primary_terms, i_secondary_terms};
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign {wr_b, bus_addr, bus_data, pt, st} = s3;

  // strobe level moves only when stages two and three agree
  always_comb begin
    next_wr_lvl = (s2[BW-1] == wr_b) ? wr_b : wr_lvl;
    wr_fall = wr_lvl && !next_wr_lvl;
    wr_rise = !wr_lvl && next_wr_lvl;
    next_cap_addr = wr_fall ? bus_addr : cap_addr; // R9
  end

  // each sector select is the OR of its product terms
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      psel[i] = |pt[i]; // R4
    end
    for (int j = 0; j < 4; j++) begin
      ssel[j] = |st[j]; // R4
    end
  end

  // decode helpers for the byte being taken at strobe rise
  logic hit_p, hit_s, cur_arr, even, same, evt;
  logic [7:0] cur_sel, cur_prot, cb, all_unprot;
  logic [11:0] lo;
  logic is_ul1, is_ul2, at_aaa;
  always_comb begin
    hit_p = |psel;
    hit_s = |ssel;
    cur_arr = !hit_p; // R5
    cur_sel = hit_p ? psel : {4'h0, ssel}; // R1
    cur_prot = hit_p ? i_primary_protect : {4'h0, i_secondary_protect};
    all_unprot = hit_p ? ~i_primary_protect : {4'h0, ~i_secondary_protect}; // R13
    evt = wr_rise && (hit_p || hit_s); // R5
    lo = cap_addr[11:0]; // R8
    cb = bus_data[7:0];
    even = !cap_addr[0]; // R22
    is_ul1 = (cb == `DFCS_B_UL1) && (lo == `DFCS_UL1_ADDR); // R7
    is_ul2 = (cb == `DFCS_B_UL2) && (lo == `DFCS_UL2_ADDR); // R7
    at_aaa = (lo == `DFCS_UL1_ADDR) && even;
  end

  // timers for byte gap or sector window, program and erase
  dfcs_tmr_if gap_if ();
  dfcs_tmr_if prog_if ();
  dfcs_tmr_if erase_if ();
  dfcs_timer u_gap (.i_clk(i_clk), .i_rstn(i_rstn), .t(gap_if.tmr));
  dfcs_timer u_prog (.i_clk(i_clk), .i_rstn(i_rstn), .t(prog_if.tmr));
  dfcs_timer u_erase (.i_clk(i_clk), .i_rstn(i_rstn), .t(erase_if.tmr));

  // sequencer state
  dfcs_state_t state, next_state;
  logic arr, next_arr, er_arr, next_er_arr;
  logic bypass, next_bypass, susp, next_susp, bulk, next_bulk;
  logic err, next_err, err_clr;
  logic [7:0] mask, next_mask;
  logic [AW-1:0] paddr, next_paddr;
  logic [15:0] pdata, next_pdata;
  logic gap_load, swin_load;

  assign same = evt && (cur_arr == arr);

  // command decoding; bytes are consumed, never written to the array
  always_comb begin
    next_state = state; // R6
    next_arr = arr;
    next_er_arr = er_arr;
    next_bypass = bypass;
    next_susp = susp;
    next_bulk = bulk;
    next_mask = mask;
    next_paddr = paddr;
    next_pdata = pdata;
    err_clr = 1'b0;
    gap_load = 1'b0;
    swin_load = 1'b0;
    prog_if.load = 1'b0;
    erase_if.load = 1'b0;
    case (state)
      DFCS_READ: begin
        if (evt && even) begin // R21
          next_arr = cur_arr;
          if (bypass && cb == `DFCS_B_PROG) begin
            next_state = DFCS_PDATA; // R17
            gap_load = 1'b1;
          end else if (bypass && cb == `DFCS_B_AUTO) begin
            next_state = DFCS_BYP90; // R18
            gap_load = 1'b1;
          end else if (susp && cb == `DFCS_B_SECT && cur_arr == er_arr) begin
            next_state = DFCS_ERASE; // R15
            next_susp = 1'b0;
          end else if (cb == `DFCS_B_RESET) begin
            err_clr = 1'b1; // R16
          end else if (!bypass && is_ul1) begin
            next_state = DFCS_UL1; // R7
            gap_load = 1'b1;
          end
        end
      end
      DFCS_UL1: begin
        if (same && is_ul2) begin
          next_state = DFCS_UL2;
          gap_load = 1'b1;
        end else if (evt || gap_if.done) begin
          next_state = DFCS_READ; // R20
        end
      end
      DFCS_UL2: begin
        next_state = DFCS_READ; // R20
        if (same && at_aaa) begin
          if (cb == `DFCS_B_AUTO) begin
            next_state = DFCS_AUTO; // R10 R11
          end else if (cb == `DFCS_B_PROG) begin
            next_state = DFCS_PDATA; // R9
            gap_load = 1'b1;
          end else if (cb == `DFCS_B_ERASE && !susp) begin
            next_state = DFCS_E80;
            gap_load = 1'b1;
          end else if (cb == `DFCS_B_BYP && !susp) begin
            next_bypass = 1'b1; // R17
          end
        end else if (!evt && !gap_if.done) begin
          next_state = DFCS_UL2;
        end
      end
      DFCS_E80: begin
        if (same && is_ul1) begin
          next_state = DFCS_E_UL1;
          gap_load = 1'b1;
        end else if (evt || gap_if.done) begin
          next_state = DFCS_READ; // R20
        end
      end
      DFCS_E_UL1: begin
        if (same && is_ul2) begin
          next_state = DFCS_E_UL2;
          gap_load = 1'b1;
        end else if (evt || gap_if.done) begin
          next_state = DFCS_READ; // R20
        end
      end
      DFCS_E_UL2: begin
        next_state = DFCS_READ; // R20
        if (same && even && cb == `DFCS_B_SECT) begin
          next_mask = cur_sel & ~cur_prot; // R12 R25
          next_state = DFCS_SWIN;
          swin_load = 1'b1;
        end else if (same && at_aaa && cb == `DFCS_B_BULK) begin
          next_mask = all_unprot; // R13
          next_bulk = 1'b1;
          next_er_arr = arr;
          if (all_unprot != 8'h00) begin
            next_state = DFCS_ERASE;
            erase_if.load = 1'b1;
          end
        end else if (!evt && !gap_if.done) begin
          next_state = DFCS_E_UL2;
        end
      end
      DFCS_SWIN: begin
        if (same && even && cb == `DFCS_B_SECT) begin
          next_mask = mask | (cur_sel & ~cur_prot); // R12
          swin_load = 1'b1;
        end else if (evt) begin
          next_state = DFCS_READ; // R20
          next_mask = 8'h00;
        end else if (gap_if.done) begin
          next_bulk = 1'b0;
          next_er_arr = arr;
          if (mask != 8'h00) begin
            next_state = DFCS_ERASE; // R2
            erase_if.load = 1'b1;
          end else begin
            next_state = DFCS_READ; // R25
          end
        end
      end
      DFCS_PDATA: begin
        if (same) begin
          // protected sector or the paused erase target drops the program
          if ((cur_sel & cur_prot) != 8'h00 ||
              (susp && arr == er_arr && (cur_sel & mask) != 8'h00)) begin
            next_state = DFCS_READ; // R25 R14
          end else begin
            next_paddr = cap_addr; // R9
            next_pdata = bus_data; // R9
            next_state = DFCS_PROG; // R19
            prog_if.load = 1'b1;
          end
        end else if (evt || gap_if.done) begin
          next_state = DFCS_READ; // R20
        end
      end
      DFCS_PROG: begin
        if (prog_if.done) begin
          next_state = DFCS_READ;
        end
      end
      DFCS_ERASE: begin
        if (erase_if.done) begin
          next_state = DFCS_READ;
          next_mask = 8'h00;
        end else if (evt && even && cur_arr == er_arr && !bulk && cb == `DFCS_B_SUSP) begin
          next_susp = 1'b1; // R14
          next_state = DFCS_READ;
        end
      end
      DFCS_AUTO: begin
        if (evt && even && cb == `DFCS_B_RESET) begin
          next_state = DFCS_READ; // R16
          err_clr = 1'b1;
        end
      end
      DFCS_BYP90: begin
        if (same && even && cb == `DFCS_B_BYPX) begin
          next_bypass = 1'b0; // R18
          next_state = DFCS_READ;
        end else if (evt || gap_if.done) begin
          next_state = DFCS_READ; // R20
        end
      end
      default: begin
        next_state = DFCS_READ;
      end
    endcase
    // a failure sets the flag only in program or erase, states where no reset command is taken
    next_err = (err && !err_clr) ||
               (i_array_fail && (state == DFCS_PROG || state == DFCS_ERASE));
  end

  // timer loads; each accepted byte that awaits a further byte restarts the gap count
  always_comb begin
    gap_if.load = gap_load || swin_load; // R19
    gap_if.value = swin_load ? dfcs_cnt_t'(SWIN_CYC) : dfcs_cnt_t'(GAP_CYC); // R24
    gap_if.hold = 1'b0;
    prog_if.value = dfcs_cnt_t'(PROG_CYC); // R24
    prog_if.hold = 1'b0;
    erase_if.value = dfcs_cnt_t'(ERASE_CYC); // R24
    erase_if.hold = susp; // R14
  end

  // read path: special answers in autoselect, array data otherwise
  logic [15:0] next_rd;
  always_comb begin
    next_rd = i_array_rdata;
    if (state == DFCS_AUTO && bus_addr[7:0] == `DFCS_ID_RD_ADDR && !arr) begin
      next_rd = ID_CODE; // R10
    end else if (state == DFCS_AUTO && bus_addr[7:0] == `DFCS_PROT_RD_ADDR) begin
      next_rd = {8'h00, ((cur_sel & cur_prot) != 8'h00) ? `DFCS_PROT_YES : `DFCS_PROT_NO}; // R11
    end
  end

  // register everything; reset leaves both arrays in read mode
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= DFCS_READ; // R23
      wr_lvl <= 1'b1;
      cap_addr <= '0;
      arr <= 1'b0;
      er_arr <= 1'b0;
      bypass <= 1'b0;
      susp <= 1'b0;
      bulk <= 1'b0;
      err <= 1'b0;
      mask <= 8'h00;
      paddr <= '0;
      pdata <= 16'h0000;
      o_read_data <= 16'h0000;
    end else begin
      state <= next_state;
      wr_lvl <= next_wr_lvl;
      cap_addr <= next_cap_addr;
      arr <= next_arr;
      er_arr <= next_er_arr;
      bypass <= next_bypass;
      susp <= next_susp;
      bulk <= next_bulk;
      err <= next_err;
      mask <= next_mask;
      paddr <= next_paddr;
      pdata <= next_pdata;
      o_read_data <= next_rd;
    end
  end

  // outputs decoded from state flops
  assign o_ready_busy_pin = !(state == DFCS_PROG || state == DFCS_ERASE); // R3
  assign o_array_prog = (state == DFCS_PROG); // R2
  assign o_array_erase = (state == DFCS_ERASE); // R2
  assign o_array_sel = o_array_erase ? er_arr : arr;
  assign o_array_addr = paddr;
  assign o_array_wdata = pdata;
  assign o_erase_mask = mask;
  assign o_error_flag_bit = err;
  assign o_bypass_mode = bypass;
  assign o_erase_paused = susp;
endmodule
`default_nettype wire

// ---- testbench/dfcs_asserts.sv ----
// port assertions for the sequencer top
`timescale 1ns/10ps
`default_nettype none
module dfcs_asserts #(
  parameter int AW = 16,
  parameter int PROG_CYC = 1000
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_write_strobe_pin_n,
  input wire logic o_ready_busy_pin,
  input wire logic o_bypass_mode,
  input wire logic o_erase_paused,
  input wire logic o_array_prog,
  input wire logic o_array_erase,
  input wire logic [AW-1:0] o_array_addr,
  input wire logic [15:0] o_array_wdata,
  input wire logic [7:0] o_erase_mask
);
  logic strb_q, next_strb_q;
  logic [7:0] since, next_since;
  // length of the current program pulse, counted so any duration parameter works
  int plen, next_plen;
  // clocks since the strobe pin last rose, saturating so old writes never look fresh
  always_comb begin
    next_strb_q = i_write_strobe_pin_n;
    next_plen = o_array_prog ? plen + 1 : 0;
    next_since = (since == 8'hFF) ? since : since + 8'h01;
    if (i_write_strobe_pin_n && !strb_q) begin
      next_since = 8'h00;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strb_q <= 1'b1;
      since <= 8'hFF;
      plen <= 0;
    end else begin
      strb_q <= next_strb_q;
      since <= next_since;
      plen <= next_plen;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_ready_tracks_busy: assert property (o_ready_busy_pin == !(o_array_prog || o_array_erase))
    else $error("ready pin disagrees with activity");
  a_prog_min_len: assert property ($rose(o_array_prog) |-> o_array_prog [*8])
    else $error("program pulse too short");
  a_prog_max_len: assert property ($fell(o_array_prog) |-> plen == PROG_CYC)
    else $error("program pulse length differs from its parameter");
  a_prog_after_write: assert property ($rose(o_array_prog) |-> since <= 8'd8)
    else $error("program began without a fresh write");
  a_prog_fields_hold: assert property (o_array_prog && $past(o_array_prog)
    |-> $stable(o_array_addr) && $stable(o_array_wdata))
    else $error("program address or data moved");
  a_pause_from_erase: assert property ($rose(o_erase_paused) |-> $past(o_array_erase))
    else $error("pause without a running erase");
  a_pause_is_idle: assert property (o_erase_paused |-> o_ready_busy_pin && !o_array_erase)
    else $error("paused erase still busy");
  a_erase_has_target: assert property ($rose(o_array_erase) |-> o_erase_mask != 8'h00)
    else $error("erase with no sector");
  a_mask_holds: assert property (o_array_erase && $past(o_array_erase) |-> $stable(o_erase_mask))
    else $error("erase mask moved mid erase");
  a_bypass_after_write: assert property ($rose(o_bypass_mode) |-> since <= 8'd8)
    else $error("bypass entered without a write");
endmodule
bind dfcs_top dfcs_asserts #(.AW(AW), .PROG_CYC(PROG_CYC)) u_asserts (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_write_strobe_pin_n(i_write_strobe_pin_n), .o_ready_busy_pin(o_ready_busy_pin),
  .o_bypass_mode(o_bypass_mode), .o_erase_paused(o_erase_paused),
  .o_array_prog(o_array_prog), .o_array_erase(o_array_erase), .o_array_addr(o_array_addr),
  .o_array_wdata(o_array_wdata), .o_erase_mask(o_erase_mask));
`default_nettype wire

// ---- testbench/dfcs_host_model.sv ----
// host bus model: byte commands and word writes with sector selects
`timescale 1ns/10ps
`default_nettype none
module dfcs_host_model (
  // clock
  input wire logic i_clk,
  // host bus pins
  output var logic o_strobe_n,
  output var logic [15:0] o_addr,
  output var logic [15:0] o_data,
  // sector select product terms
  output var logic [7:0][2:0] o_p_terms,
  output var logic [3:0][2:0] o_s_terms
);
  // strobe idles high so no write is seen at reset release
  initial begin
    o_strobe_n = 1'b1;
    o_addr = 16'h0000;
    o_data = 16'h0000;
    o_p_terms = '0;
    o_s_terms = '0;
  end
  // one select high, term index varies with sector to exercise the or
  task automatic drive_sel(input logic sec, input int s);
    logic [23:0] p;
    logic [11:0] q;
    p = '0;
    q = '0;
    if (sec) q[s * 3 + s % 3] = 1'b1;
    else p[s * 3 + s % 3] = 1'b1;
    o_p_terms <= p;
    o_s_terms <= q;
  endtask
  // one write cycle, address and selects held well past both strobe edges
  task automatic wr(input logic sec, input int s, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_data <= d;
    drive_sel(sec, s);
    o_strobe_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    o_strobe_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_data <= ~d; // released bus never shows the old word
    o_p_terms <= '0;
    o_s_terms <= '0;
  endtask
  // read: address and select, then time for the synchroniser and register
  task automatic rd(input logic sec, input int s, input logic [15:0] a);
    @(posedge i_clk);
    o_addr <= a;
    drive_sel(sec, s);
    repeat (6) @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- testbench/dfcs_tb_top.sv ----
// self-checking bench for the dual flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module dfcs_tb_top;
  import dfcs_pkg::*;
  typedef struct {logic sec; int s; logic [15:0] pa; logic [15:0] pd;} dfcs_row_t;
  localparam logic [15:0] ID = 16'h005A; // arbitrary value
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic strb_n, rdy, err, byp, paused, prog, erase, asel;
  logic [15:0] addr, wdat, rdat, aaddr, awdat;
  logic [7:0][2:0] p_terms;
  logic [3:0][2:0] s_terms;
  logic [7:0] mask;
  // protection, array data and fault inputs; primary protection and fault changed by the scenarios below
  logic afail = 1'b0;
  logic [7:0] pprot = 8'h08;
  logic [3:0] sprot = 4'h2;
  logic [15:0] ardat = 16'h1234;
  int fail_count = 0;
  int comparisons = 0;
  dfcs_row_t rows[3] = '{'{1'b0, 1, 16'h2468, 16'hBEEF}, '{1'b1, 2, 16'h0100, 16'h0A5C},
    '{1'b0, 5, 16'h9ABC, 16'h0001}};
  always #5 i_clk = ~i_clk;
  dfcs_host_model host (.i_clk(i_clk), .o_strobe_n(strb_n), .o_addr(addr), .o_data(wdat),
    .o_p_terms(p_terms), .o_s_terms(s_terms));
  // sector 3 primary and sector 1 secondary protected at start
  dfcs_top #(.GAP_CYC(20), .SWIN_CYC(30), .PROG_CYC(10), .ERASE_CYC(40), .ID_CODE(ID)) uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_write_strobe_pin_n(strb_n), .i_addr(addr),
    .i_data(wdat), .i_primary_terms(p_terms), .i_secondary_terms(s_terms),
    .i_primary_protect(pprot), .i_secondary_protect(sprot), .i_array_rdata(ardat),
    .i_array_fail(afail), .o_ready_busy_pin(rdy), .o_error_flag_bit(err), .o_bypass_mode(byp),
    .o_erase_paused(paused), .o_read_data(rdat), .o_array_prog(prog), .o_array_erase(erase),
    .o_array_sel(asel), .o_array_addr(aaddr), .o_array_wdata(awdat), .o_erase_mask(mask));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return prog;
      1: return erase;
      default: return rdy;
    endcase
  endfunction
  // bounded wait on program, erase or ready
  task automatic wait_on(input int w, input logic lvl);
    for (int i = 0; i < 300; i++) begin
      @(posedge i_clk);
      #1;
      if (pick(w) === lvl) return;
    end
    fail_count++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, ~lvl, lvl);
    complete_run();
  endtask
  task automatic settle;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic ul(input logic sec, input int s, input logic [3:0] hi);
    host.wr(sec, s, {hi, 12'hAAA}, 16'h00AA);
    host.wr(sec, s, {hi, 12'h554}, 16'h0055);
  endtask
  task automatic cmd(input logic sec, input int s, input logic [7:0] b);
    ul(sec, s, 4'h0);
    host.wr(sec, s, 16'h0AAA, {8'h00, b});
  endtask
  initial begin
    @(posedge i_clk);
    #1;
    chk({12'h000, rdy, byp, paused, prog}, 16'h0008);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    // ordinary word programs on both arrays, upper address bits varied
    foreach (rows[k]) begin
      ul(rows[k].sec, rows[k].s, 4'(k * 5));
      host.wr(rows[k].sec, rows[k].s, 16'h0AAA, 16'h00A0);
      host.wr(rows[k].sec, rows[k].s, rows[k].pa, rows[k].pd);
      wait_on(0, 1'b1);
      chk(aaddr, rows[k].pa);
      chk(awdat, rows[k].pd);
      chk({15'h0, asel}, {15'h0, rows[k].sec});
      chk({15'h0, rdy}, 16'h0000);
      wait_on(2, 1'b1);
    end
    // program aimed at a protected sector
    cmd(0, 3, 8'hA0);
    host.wr(0, 3, 16'h6000, 16'h1111);
    // a wrongly started program would already be busy here
    #1;
    chk({15'h0, rdy}, 16'h0001);
    // gap too long between unlock and command
    ul(0, 0, 4'h0);
    repeat (30) @(posedge i_clk);
    host.wr(0, 0, 16'h0AAA, 16'h00A0);
    host.wr(0, 0, 16'h0010, 16'h2222);
    #1;
    chk({15'h0, rdy}, 16'h0001);
    // two queued sectors, pause and resume
    cmd(0, 2, 8'h80);
    ul(0, 2, 4'h0);
    host.wr(0, 2, 16'h4000, 16'h0030);
    host.wr(0, 6, 16'hC000, 16'h0030);
    wait_on(1, 1'b1);
    chk({8'h00, mask}, 16'h0044);
    host.wr(0, 2, 16'h4000, 16'h00B0);
    settle();
    chk({14'h0, paused, rdy}, 16'h0003);
    host.wr(0, 2, 16'h4000, 16'h0030);
    wait_on(1, 1'b1);
    wait_on(2, 1'b1);
    chk({15'h0, paused}, 16'h0000);
    host.wr(0, 0, 16'h0000, 16'h00B0);
    settle();
    chk({15'h0, paused}, 16'h0000);
    // whole secondary array, sector 1 protected
    cmd(1, 1, 8'h80);
    ul(1, 1, 4'h0);
    host.wr(1, 1, 16'h0AAA, 16'h0010);
    wait_on(1, 1'b1);
    chk({7'h00, asel, mask}, 16'h010D);
    wait_on(2, 1'b1);
    // identifier and protection reads, then back to plain reads
    cmd(0, 0, 8'h90);
    host.rd(0, 0, 16'h0002);
    chk(rdat, ID);
    host.rd(0, 3, 16'h0004);
    chk(rdat, 16'h0001);
    host.rd(0, 1, 16'h0004);
    chk(rdat, 16'h0000);
    @(posedge i_clk);
    pprot <= 8'h0A;
    host.rd(0, 1, 16'h0004);
    chk(rdat, 16'h0001);
    host.wr(0, 0, 16'h0000, 16'h00F0);
    // identifier location again: array data only once read mode is back
    host.rd(0, 1, 16'h0102);
    chk(rdat, 16'h1234);
    // bypass entry, short program, exit
    cmd(0, 4, 8'h20);
    settle();
    chk({15'h0, byp}, 16'h0001);
    host.wr(0, 4, 16'h0F00, 16'h00A0);
    host.wr(0, 4, 16'h8000, 16'h00C3);
    wait_on(0, 1'b1);
    chk(awdat, 16'h00C3);
    // array fault during the program sets the sticky error flag
    @(posedge i_clk);
    afail <= 1'b1;
    wait_on(2, 1'b1);
    @(posedge i_clk);
    afail <= 1'b0;
    host.wr(0, 4, 16'h0F00, 16'h0090);
    host.wr(0, 4, 16'h0F00, 16'h0000);
    settle();
    chk({15'h0, byp}, 16'h0000);
    chk({15'h0, err}, 16'h0001);
    host.wr(0, 0, 16'h0000, 16'h00F0);
    settle();
    chk({15'h0, err}, 16'h0000);
    // mid-run reset drops bypass and leaves read mode
    cmd(0, 4, 8'h20);
    settle();
    chk({14'h0, byp, rdy}, 16'h0003);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    settle();
    chk({14'h0, byp, rdy}, 16'h0001);
    complete_run();
  end
endmodule
`default_nettype wire
